// ==== tb/khmf_assertions.sv ====
// Port checks of the keyboard mailbox.
`include "khmf_map.vh"
module khmf_assertions (
	input wire       mclk,
	input wire       nrst,
	input wire [2:0] host_addr,
	input wire       host_wr,
	input wire       host_rd,
	input wire [7:0] host_rdata,
	input wire [2:0] cpu_addr,
	input wire [7:0] cpu_wdata,
	input wire       cpu_wr,
	input wire       cpu_rd,
	input wire       kbd_irq_out,
	input wire       aux_irq_out,
	input wire       gate_a20_out,
	input wire [2:0] port1_pin_out,
	input wire [2:0] port1_pin_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cfg_q, p1_q, p2_q, hcnt_q;
	logic       ofl_q, ifl_q;
	wire        hsel = host_addr[`KHMF_HOST_SEL_BIT];
	wire        cbuf = cpu_addr == `KHMF_CPU_BUF_OFS;
	wire        flg  = cfg_q[`KHMF_CFG_FLAGS];
	wire        ctl  = cfg_q[`KHMF_CFG_CTRL];
	wire        od   = cfg_q[`KHMF_CFG_ODRAIN];

	// ****************************************************************
	// Shadow of the configuration and port registers and both flags; set wins over clear.
	// ****************************************************************
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cfg_q  <= `KHMF_CFG_RST;
			p1_q   <= `KHMF_PORT1_RST;
			p2_q   <= `KHMF_PORT2_RST;
			hcnt_q <= 8'h00;
			ofl_q  <= 1'b0;
			ifl_q  <= 1'b0;
		end
		else
		begin
			if (cpu_wr && cpu_addr == `KHMF_CPU_CFG_OFS)
				cfg_q <= cpu_wdata | {7'h00, flg};
			if (cpu_wr && cpu_addr == `KHMF_CPU_PORT2_OFS)
				p2_q <= cpu_wdata;
			if (cpu_wr && cpu_addr == `KHMF_CPU_PORT1_OFS)
				p1_q <= cpu_wdata;
			ofl_q  <= (cpu_wr && cbuf) || (ofl_q && !(host_rd && !hsel));
			ifl_q  <= host_wr || (ifl_q && !(cpu_rd && cbuf));
			hcnt_q <= (port1_pin_oe[0] && port1_pin_out[0]) ? hcnt_q + 8'h01 : 8'h00;
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	AST_FLAG_CD:
	assert property (host_wr ##1 (host_rd && hsel) |=>
		host_rdata[`KHMF_ST_IFL] && host_rdata[`KHMF_ST_CMD] == $past(hsel, 2))
		else $error("status flags wrong after host write");
	AST_KBD_FLAGS:
	assert property (flg && p2_q[`KHMF_P2_KBD] |=> kbd_irq_out == $past(ofl_q))
		else $error("kbd irq does not follow output full");
	AST_KBD_LOW:
	assert property (flg && !p2_q[`KHMF_P2_KBD] |=> !kbd_irq_out)
		else $error("kbd irq not forced low");
	AST_KBD_RST:
	assert property ($rose(nrst) |-> !kbd_irq_out)
		else $error("kbd irq high after reset");
	AST_KBD_PORT:
	assert property (!flg |=> kbd_irq_out == $past(p2_q[`KHMF_P2_KBD]))
		else $error("kbd irq does not follow port bit");
	AST_AIRQ_FLAGS:
	assert property (flg && p2_q[`KHMF_P2_AIRQ] |=> aux_irq_out == !$past(ifl_q))
		else $error("aux irq not inverse of input full");
	AST_AIRQ_PORT:
	assert property (!flg |=> aux_irq_out == $past(p2_q[`KHMF_P2_AIRQ]))
		else $error("aux irq does not follow port bit");
	AST_GATE:
	assert property (gate_a20_out == $past(p2_q[`KHMF_P2_GATE]))
		else $error("gate output does not follow port bit");
	AST_PIN_LOW:
	assert property (ctl && !p1_q[2] |=> port1_pin_oe[0] && !port1_pin_out[0])
		else $error("pin not driven low");
	AST_PULSE:
	assert property ($fell(port1_pin_oe[0]) && $past(port1_pin_out[0]) && ctl && !od |->
		hcnt_q == 8'h7D)
		else $error("high pulse length wrong");
	AST_ODRAIN:
	assert property (ctl && od && p1_q[2] |=> !port1_pin_oe[0])
		else $error("open drain pin driven");

	// Main scenarios.
	cover property (host_wr ##1 (host_rd && hsel));
	cover property ($fell(port1_pin_oe[0]) && ctl && !od);
	cover property (flg && kbd_irq_out);
endmodule // khmf_assertions

bind khmf_mailbox khmf_assertions u_chk (.*);

// ==== tb/khmf_host.sv ====
// Host processor model that reads and writes the mailbox registers.
module khmf_host (
	input  wire        mclk,
	output logic [2:0] host_addr,
	output logic [7:0] host_wdata,
	output logic       host_wr,
	output logic       host_rd,
	input  wire  [7:0] host_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// The bus is idle at time zero.
	initial
	begin
		host_addr  = 3'h0;
		host_wdata = 8'h00;
		host_wr    = 1'b0;
		host_rd    = 1'b0;
	end

	// Callers write only while the input byte is empty.
	// Two writes need a gap cycle, so the strobe is never set twice in one step.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		host_addr  <= a;
		host_wdata <= d;
		host_wr    <= 1'b1;
		@(posedge mclk);
		host_wr    <= 1'b0;
		host_wdata <= ~d;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [2:0] a, output logic [7:0] q);
		host_addr <= a;
		host_rd   <= 1'b1;
		@(posedge mclk);
		host_rd   <= 1'b0;
		@(posedge mclk);
		q = host_rdata;
	endtask
endmodule // khmf_host

// ==== tb/khmf_mailbox_tb.sv ====
// Self-checking bench of the keyboard mailbox with the host model on its far side.
`include "khmf_map.vh"
module khmf_mailbox_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk      = 1'b0;
	logic       nrst      = 1'b0;
	logic [2:0] cpu_addr  = 3'h0;
	logic [7:0] cpu_wdata = 8'h00;
	logic       cpu_wr    = 1'b0;
	logic       cpu_rd    = 1'b0;
	wire  [2:0] host_addr, port1_pin_out, port1_pin_oe;
	wire  [7:0] host_wdata, host_rdata, cpu_rdata;
	wire        host_wr, host_rd, cpu_irq, kbd_irq_out, aux_irq_out, gate_a20_out;
	// Released pins are held high by their pull-ups.
	wire  [2:0] port1_pin_in = ~port1_pin_oe | port1_pin_out;
	int         err_count = 0;
	int         tests_run = 0;

	khmf_mailbox uut (.*);
	khmf_host h (.*);

	// A 250 MHz clock.
	always #2 mclk = ~mclk;

	// Cuts a hung run short.
	initial
	begin
		#20us;
		err_count++;
		end_sim();
	end

	// ****************************************************************
	// Bus tasks and compare.
	// ****************************************************************
	task automatic end_sim;
		if (err_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// A gap cycle after each write keeps the strobe to one assignment per step.
	task automatic cw(input logic [2:0] a, input logic [7:0] d);
		cpu_addr  <= a;
		cpu_wdata <= d;
		cpu_wr    <= 1'b1;
		@(posedge mclk);
		cpu_wr    <= 1'b0;
		cpu_wdata <= ~d;
		@(posedge mclk);
	endtask
	task automatic cr(input logic [2:0] a, output logic [7:0] q);
		cpu_addr <= a;
		cpu_rd   <= 1'b1;
		@(posedge mclk);
		cpu_rd   <= 1'b0;
		@(posedge mclk);
		q = cpu_rdata;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Counts cycles in which pin 0 is actively driven high.
	task automatic cnt(input int n, output logic [7:0] c);
		c = 8'h00;
		repeat (n)
		begin
			@(posedge mclk);
			if (port1_pin_oe[0] && port1_pin_out[0])
				c++;
		end
	endtask

	// ****************************************************************
	// Tests.
	// ****************************************************************
	initial
	begin
		logic [7:0] v;
		wt(4);
		nrst <= 1'b1;
		wt(2);
		chk("kbd_irq", 8'h00, {7'h00, kbd_irq_out});
		h.rd(`KHMF_HOST_CMD_OFS, v);
		chk("status", 8'h00, v);
		cr(`KHMF_CPU_CFG_OFS, v);
		chk("cfg", `KHMF_CFG_RST, v);
		// Data and command bytes, event mask and clear on read.
		cw(`KHMF_CPU_MASK_OFS, 8'h04);
		h.wr(`KHMF_HOST_DATA_OFS, 8'h5A);
		h.rd(`KHMF_HOST_CMD_OFS, v);
		chk("st_data", 8'h02, v & 8'h0A);
		chk("cpu_irq", 8'h00, {7'h00, cpu_irq});
		cr(`KHMF_CPU_BUF_OFS, v);
		chk("in_data", 8'h5A, v);
		h.wr(`KHMF_HOST_CMD_OFS, 8'hA5);
		h.rd(`KHMF_HOST_CMD_OFS, v);
		chk("st_cmd", 8'h0A, v & 8'h0A);
		chk("cpu_irq", 8'h01, {7'h00, cpu_irq});
		cr(`KHMF_CPU_BUF_OFS, v);
		chk("in_cmd", 8'hA5, v);
		h.rd(`KHMF_HOST_CMD_OFS, v);
		chk("st_empty", 8'h00, v & 8'h02);
		cr(`KHMF_CPU_EVT_OFS, v);
		chk("events", 8'h05, v);
		wt(2);
		chk("cpu_irq", 8'h00, {7'h00, cpu_irq});
		// Flags disabled: outputs follow the port bits.
		cw(`KHMF_CPU_PORT2_OFS, 8'h30);
		wt(2);
		chk("irqs", 8'h03, {6'h00, kbd_irq_out, aux_irq_out});
		// Firmware sets user bits 7 and 2 and the aux flag; a read with flags off must keep the aux flag.
		cw(`KHMF_CPU_STAT_OFS, 8'hA4);
		cw(`KHMF_CPU_BUF_OFS, 8'h3C);
		h.rd(`KHMF_HOST_DATA_OFS, v);
		chk("out_data", 8'h3C, v);
		wt(2);
		chk("kbd_irq", 8'h01, {7'h00, kbd_irq_out});
		h.rd(`KHMF_HOST_CMD_OFS, v);
		chk("st_aux", 8'hAC, v);
		cw(`KHMF_CPU_PORT2_OFS, 8'h02);
		wt(2);
		chk("gate_irqs", 8'h04, {5'h00, gate_a20_out, kbd_irq_out, aux_irq_out});
		// Flags enabled: outputs follow the mailbox flags.
		cw(`KHMF_CPU_CFG_OFS, 8'h05);
		cw(`KHMF_CPU_PORT2_OFS, 8'h30);
		wt(2);
		chk("irqs", 8'h01, {6'h00, kbd_irq_out, aux_irq_out});
		cw(`KHMF_CPU_BUF_OFS, 8'h77);
		wt(2);
		chk("kbd_irq", 8'h01, {7'h00, kbd_irq_out});
		repeat (2)
		begin
			h.rd(`KHMF_HOST_CMD_OFS, v);
			chk("st_full", 8'h01, v & 8'h01);
		end
		h.rd(`KHMF_HOST_DATA_OFS, v);
		chk("out_data", 8'h77, v);
		wt(1);
		chk("kbd_irq", 8'h00, {7'h00, kbd_irq_out});
		// With flags on the data read also released the aux flag; user bits stay.
		h.rd(`KHMF_HOST_CMD_OFS, v);
		chk("st_drained", 8'h8C, v);
		h.wr(`KHMF_HOST_DATA_OFS, 8'h11);
		wt(2);
		chk("aux_irq", 8'h00, {7'h00, aux_irq_out});
		cr(`KHMF_CPU_BUF_OFS, v);
		chk("in_data", 8'h11, v);
		wt(1);
		chk("aux_irq", 8'h01, {7'h00, aux_irq_out});
		cw(`KHMF_CPU_PORT2_OFS, 8'h20);
		cw(`KHMF_CPU_BUF_OFS, 8'h22);
		wt(2);
		chk("kbd_irq", 8'h00, {7'h00, kbd_irq_out});
		cw(`KHMF_CPU_MASK_OFS, 8'h02);
		wt(1);
		chk("cpu_irq", 8'h01, {7'h00, cpu_irq});
		cr(`KHMF_CPU_EVT_OFS, v);
		chk("events", 8'h03, v);
		cw(3'h7, 8'hFF);
		cr(3'h7, v);
		chk("unmapped", 8'h00, v);
		// Quasi pins: low drive, then a high pulse.
		cw(`KHMF_CPU_PORT1_OFS, 8'hC0);
		wt(2);
		chk("pin_low", 8'h02, {6'h00, port1_pin_oe[0], port1_pin_out[0]});
		cw(`KHMF_CPU_PORT1_OFS, 8'hC4);
		cnt(200, v);
		chk("pulse", 8'h7D, v);
		cr(`KHMF_CPU_PORT1_OFS, v);
		chk("pins", 8'hC4, v);
		// Open drain with direction and inversion settings that must be ignored.
		cw(`KHMF_CPU_CFG_OFS, 8'h1F);
		cw(`KHMF_CPU_PORT1_OFS, 8'hC0);
		wt(4);
		chk("od_low", 8'h02, {6'h00, port1_pin_oe[0], port1_pin_out[0]});
		cr(`KHMF_CPU_PORT1_OFS, v);
		chk("pins", 8'hC0, v);
		cw(`KHMF_CPU_PORT1_OFS, 8'hC4);
		cnt(20, v);
		chk("od_pulse", 8'h00, v);
		cr(`KHMF_CPU_PORT1_OFS, v);
		chk("pins", 8'hC4, v);
		end_sim();
	end
endmodule // khmf_mailbox_tb

// ==== verilog/khmf_mailbox.v ====
// Host mailbox of the embedded keyboard controller with interrupt gating and port pins.
`include "khmf_map.vh"
module khmf_mailbox (
	input  wire                     mclk,
	input  wire                     nrst,
	// Host register port.
	input  wire [`KHMF_HOST_AW-1:0] host_addr,
	input  wire [7:0]               host_wdata,
	input  wire                     host_wr,
	input  wire                     host_rd,
	output wire [7:0]               host_rdata,
	// Internal CPU register port.
	input  wire [`KHMF_CPU_AW-1:0]  cpu_addr,
	input  wire [7:0]               cpu_wdata,
	input  wire                     cpu_wr,
	input  wire                     cpu_rd,
	output wire [7:0]               cpu_rdata,
	output wire                     cpu_irq,
	// System side outputs.
	output wire                     kbd_irq_out,
	output wire                     aux_irq_out,
	output wire                     gate_a20_out,
	// Port 1 pins, bits 7, 6 and 2, as three signals each.
	input  wire [2:0]               port1_pin_in,
	output wire [2:0]               port1_pin_out,
	output wire [2:0]               port1_pin_oe
);

	// ****************************************************************
	// State.
	// ****************************************************************
	reg  [7:0]            in_buf_q;
	reg  [7:0]            out_buf_q;
	reg                   input_full_flag_q;
	reg                   output_full_flag_q;
	reg                   cmd_flag_q;
	reg                   aux_output_full_q;
	reg  [7:0]            user_stat_q;
	reg  [7:0]            port2_q;
	reg  [7:0]            port1_q;
	reg  [7:0]            cfg_q;
	reg  [`KHMF_EV_W-1:0] evt_q;
	reg  [`KHMF_EV_W-1:0] mask_q;
	reg  [7:0]            host_rdata_q;
	reg  [7:0]            cpu_rdata_q;
	reg                   cpu_irq_q;
	reg                   kbd_irq_q;
	reg                   aux_irq_q;
	reg                   gate_q;

	reg  [`KHMF_EV_W-1:0] evt_d;
	reg                   kbd_irq_d;
	reg                   aux_irq_d;
	reg  [7:0]            host_rdata_d;
	reg  [7:0]            cpu_rdata_d;

	wire [7:0]            status;
	wire [2:0]            pin_sync;
	wire [2:0]            pin_val;
	wire                  flags_en;

	// ****************************************************************
	// Decode of both register ports.
	// ****************************************************************
	// Host selects by address bit 2 alone; the low bits are don't-care.
	wire host_sel_cmd = host_addr[`KHMF_HOST_SEL_BIT];
	wire host_wr_any  = host_wr;
	wire host_wr_cmd  = host_wr && host_sel_cmd;
	wire host_rd_data = host_rd && !host_sel_cmd;
	wire host_rd_stat = host_rd && host_sel_cmd;

	wire cpu_wr_buf   = cpu_wr && (cpu_addr == `KHMF_CPU_BUF_OFS);
	wire cpu_rd_buf   = cpu_rd && (cpu_addr == `KHMF_CPU_BUF_OFS);
	wire cpu_wr_stat  = cpu_wr && (cpu_addr == `KHMF_CPU_STAT_OFS);
	wire cpu_wr_p2    = cpu_wr && (cpu_addr == `KHMF_CPU_PORT2_OFS);
	wire cpu_wr_p1    = cpu_wr && (cpu_addr == `KHMF_CPU_PORT1_OFS);
	wire cpu_wr_cfg   = cpu_wr && (cpu_addr == `KHMF_CPU_CFG_OFS);
	wire cpu_rd_evt   = cpu_rd && (cpu_addr == `KHMF_CPU_EVT_OFS);
	wire cpu_wr_mask  = cpu_wr && (cpu_addr == `KHMF_CPU_MASK_OFS);

	assign flags_en = cfg_q[`KHMF_CFG_FLAGS];

	// ****************************************************************
	// Host status byte, assembled from the flag flops.
	// ****************************************************************
	// Reading it has no effect on any flag or buffer.
	assign status = (user_stat_q & `KHMF_ST_USER_MASK)
		| ({7'h00, output_full_flag_q} << `KHMF_ST_OFL)
		| ({7'h00, input_full_flag_q} << `KHMF_ST_IFL)
		| ({7'h00, cmd_flag_q} << `KHMF_ST_CMD)
		| ({7'h00, aux_output_full_q} << `KHMF_ST_AUXOF);

	// ****************************************************************
	// Input side: host to CPU.
	// ****************************************************************
	// A host write lands the byte and raises input-full; the command flag copies
	// address bit 2. A same-cycle CPU read loses to the host write, so no byte is
	// ever silently dropped from the flag's point of view.
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			in_buf_q          <= 8'h00;
			input_full_flag_q <= 1'b0;
			cmd_flag_q        <= 1'b0;
		end
		else
		begin
			if (host_wr_any)
			begin
				in_buf_q          <= host_wdata;
				input_full_flag_q <= 1'b1;
				cmd_flag_q        <= host_wr_cmd;
			end
			else if (cpu_rd_buf)
				input_full_flag_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Output side: CPU to host.
	// ****************************************************************
	// A CPU write of the output buffer sets output-full; it wins over a host
	// read in the same cycle. Otherwise a host data read empties the buffer; the aux
	// flag is only released by the read once flags are enabled, otherwise
	// firmware clears it through the status register.
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			out_buf_q          <= 8'h00;
			output_full_flag_q <= 1'b0;
			aux_output_full_q  <= 1'b0;
			user_stat_q        <= 8'h00;
		end
		else
		begin
			if (cpu_wr_buf)
			begin
				out_buf_q          <= cpu_wdata;
				output_full_flag_q <= 1'b1;
			end
			else if (host_rd_data)
				output_full_flag_q <= 1'b0;

			if (cpu_wr_stat)
			begin
				user_stat_q       <= cpu_wdata & `KHMF_ST_USER_MASK;
				aux_output_full_q <= cpu_wdata[`KHMF_ST_AUXOF];
			end
			else if (host_rd_data && flags_en)
				aux_output_full_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Port, configuration and mask registers written by the CPU.
	// ****************************************************************
	// The flags enable is set-only: once executed it holds until reset, as the
	// controller offers no way to undo it.
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			port2_q <= `KHMF_PORT2_RST;
			port1_q <= `KHMF_PORT1_RST;
			cfg_q   <= `KHMF_CFG_RST;
			mask_q  <= {`KHMF_EV_W{1'b0}};
		end
		else
		begin
			if (cpu_wr_p2)
				port2_q <= cpu_wdata;
			if (cpu_wr_p1)
				port1_q <= cpu_wdata;
			if (cpu_wr_cfg)
				cfg_q <= cpu_wdata | {7'h00, flags_en};
			if (cpu_wr_mask)
				mask_q <= cpu_wdata[`KHMF_EV_W-1:0];
		end
	end

	// ****************************************************************
	// Interrupt lines toward the system.
	// ****************************************************************
	// Without flags enabled both lines are plain port bits; with flags enabled
	// they are gated buffer flags, so host software can poll or take interrupts.
	always @*
	begin
		if (flags_en)
		begin
			kbd_irq_d = port2_q[`KHMF_P2_KBD] && output_full_flag_q;
			aux_irq_d = port2_q[`KHMF_P2_AIRQ] && !input_full_flag_q;
		end
		else
		begin
			kbd_irq_d = port2_q[`KHMF_P2_KBD];
			aux_irq_d = port2_q[`KHMF_P2_AIRQ];
		end
	end

	// Registered outputs keep the system lines glitch-free; they lag one cycle.
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			kbd_irq_q <= 1'b0;
			aux_irq_q <= 1'b0;
			gate_q    <= 1'b0;
		end
		else
		begin
			kbd_irq_q <= kbd_irq_d;
			aux_irq_q <= aux_irq_d;
			gate_q    <= port2_q[`KHMF_P2_GATE];
		end
	end

	// ****************************************************************
	// CPU event status, mask and interrupt.
	// ****************************************************************
	// Events are sticky and cleared by reading; an event that arrives in the
	// reading cycle survives the clear so that it is reported next time.
	always @*
	begin
		evt_d = evt_q;
		if (cpu_rd_evt)
			evt_d = {`KHMF_EV_W{1'b0}};
		if (host_wr_any)
			evt_d[`KHMF_EV_IN] = 1'b1;
		if (host_rd_data)
			evt_d[`KHMF_EV_DRAIN] = 1'b1;
		if (host_wr_cmd)
			evt_d[`KHMF_EV_CMD] = 1'b1;
	end

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			evt_q     <= {`KHMF_EV_W{1'b0}};
			cpu_irq_q <= 1'b0;
		end
		else
		begin
			evt_q     <= evt_d;
			cpu_irq_q <= |(evt_d & mask_q);
		end
	end

	// ****************************************************************
	// Read data of both ports, valid in the cycle after the strobe.
	// ****************************************************************
	always @*
	begin
		host_rdata_d = 8'h00;
		if (host_rd_data)
			host_rdata_d = out_buf_q;
		else if (host_rd_stat)
			host_rdata_d = status;
	end

	always @*
	begin
		cpu_rdata_d = 8'h00;
		if (cpu_rd)
		begin
			case (cpu_addr)
				`KHMF_CPU_BUF_OFS:   cpu_rdata_d = in_buf_q;
				`KHMF_CPU_STAT_OFS:  cpu_rdata_d = status;
				`KHMF_CPU_PORT2_OFS: cpu_rdata_d = port2_q;
				`KHMF_CPU_PORT1_OFS: cpu_rdata_d = {pin_val[2], pin_val[1], 3'h0, pin_val[0], 2'h0};
				`KHMF_CPU_CFG_OFS:   cpu_rdata_d = cfg_q;
				`KHMF_CPU_EVT_OFS:   cpu_rdata_d = {5'h00, evt_q};
				`KHMF_CPU_MASK_OFS:  cpu_rdata_d = {5'h00, mask_q};
				default:             cpu_rdata_d = 8'h00;
			endcase
		end
	end

	// Read data drop back to zero after one cycle so stale bytes never linger.
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			host_rdata_q <= 8'h00;
			cpu_rdata_q  <= 8'h00;
		end
		else
		begin
			host_rdata_q <= host_rdata_d;
			cpu_rdata_q  <= cpu_rdata_d;
		end
	end

	// ****************************************************************
	// Controller port pins.
	// ****************************************************************
	// Pin levels come from outside the clock domain and are synchronised.
	khmf_sync #(
		.W        (3)
	) u_pin_sync (
		.mclk     (mclk),
		.nrst     (nrst),
		.async_in (port1_pin_in),
		.sync_out (pin_sync)
	);

	// Inversion only applies outside controller mode.
	assign pin_val = cfg_q[`KHMF_CFG_CTRL] ? pin_sync : (pin_sync ^ {3{cfg_q[`KHMF_CFG_GPINV]}});

	// Pin order is bits 2, 6 and 7 of the port register.
	wire [2:0] port_bits = {port1_q[7], port1_q[6], port1_q[2]};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_pin
			khmf_qpin u_pin (
				.mclk       (mclk),
				.nrst       (nrst),
				.port_val   (port_bits[gi]),
				.open_drain (cfg_q[`KHMF_CFG_ODRAIN]),
				.ctrl_mode  (cfg_q[`KHMF_CFG_CTRL]),
				.gp_dir_in  (cfg_q[`KHMF_CFG_GPDIR]),
				.gp_inv     (cfg_q[`KHMF_CFG_GPINV]),
				.pin_out    (port1_pin_out[gi]),
				.pin_oe     (port1_pin_oe[gi])
			);
		end
	endgenerate

	// ****************************************************************
	// Output assignments, all straight from flops.
	// ****************************************************************
	assign host_rdata   = host_rdata_q;
	assign cpu_rdata    = cpu_rdata_q;
	assign cpu_irq      = cpu_irq_q;
	assign kbd_irq_out  = kbd_irq_q;
	assign aux_irq_out  = aux_irq_q;
	assign gate_a20_out = gate_q;

endmodule // khmf_mailbox

// ==== verilog/khmf_map.vh ====
// Register offsets, field positions, reset values and timing figures of the keyboard mailbox.
`ifndef KHMF_MAP_VH
`define KHMF_MAP_VH

// ****************************************************************
// Host side register offsets (address bit 2 selects the register).
// ****************************************************************
`define KHMF_HOST_AW          3
`define KHMF_HOST_DATA_OFS    3'h0
`define KHMF_HOST_CMD_OFS     3'h4
`define KHMF_HOST_SEL_BIT     2

// ****************************************************************
// Internal CPU register offsets.
// ****************************************************************
`define KHMF_CPU_AW           3
`define KHMF_CPU_BUF_OFS      3'h0
`define KHMF_CPU_STAT_OFS     3'h1
`define KHMF_CPU_PORT2_OFS    3'h2
`define KHMF_CPU_PORT1_OFS    3'h3
`define KHMF_CPU_CFG_OFS      3'h4
`define KHMF_CPU_EVT_OFS      3'h5
`define KHMF_CPU_MASK_OFS     3'h6

// ****************************************************************
// Host status register fields.
// ****************************************************************
`define KHMF_ST_OFL           0
`define KHMF_ST_IFL           1
`define KHMF_ST_CMD           3
`define KHMF_ST_AUXOF         5
`define KHMF_ST_USER_MASK     8'hD4

// ****************************************************************
// Port and configuration fields.
// ****************************************************************
`define KHMF_P2_GATE          1
`define KHMF_P2_KBD           4
`define KHMF_P2_AIRQ          5
`define KHMF_CFG_FLAGS        0
`define KHMF_CFG_ODRAIN       1
`define KHMF_CFG_CTRL         2
`define KHMF_CFG_GPDIR        3
`define KHMF_CFG_GPINV        4
`define KHMF_CFG_RST          8'h04
`define KHMF_PORT2_RST        8'h00
`define KHMF_PORT1_RST        8'hC4

// ****************************************************************
// Event bits: input filled, output drained, command received.
// ****************************************************************
`define KHMF_EV_IN            0
`define KHMF_EV_DRAIN         1
`define KHMF_EV_CMD           2
`define KHMF_EV_W             3

// ****************************************************************
// Timing: high drive pulse of the quasi-bidirectional pins.
// ****************************************************************
`define KHMF_PULSE_NS         500
`define KHMF_CLK_NS           4

`endif

// ==== verilog/khmf_qpin.v ====
// Driver of one quasi-bidirectional or open-drain controller port pin.
`include "khmf_map.vh"
module khmf_qpin (
	input  wire mclk,
	input  wire nrst,
	input  wire port_val,
	input  wire open_drain,
	input  wire ctrl_mode,
	input  wire gp_dir_in,
	input  wire gp_inv,
	output wire pin_out,
	output wire pin_oe
);

	localparam integer PULSE_INT = `KHMF_PULSE_NS / `KHMF_CLK_NS;
	localparam [7:0]   PULSE_CYC = PULSE_INT[7:0];

	reg [7:0] cnt_q;
	reg       prev_q;
	reg       out_q;
	reg       oe_q;
	reg [7:0] cnt_d;
	reg       out_d;
	reg       oe_d;
	reg       val;

	// In controller mode the general purpose direction and inversion are ignored.
	always @*
	begin
		val   = ctrl_mode ? port_val : (port_val ^ gp_inv);
		cnt_d = (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;
		out_d = val;
		oe_d  = 1'b1;
		if (!ctrl_mode && gp_dir_in)
			oe_d = 1'b0;
		else if (!val)
		begin
			cnt_d = 8'h00;
			oe_d  = 1'b1;
		end
		else if (open_drain)
			oe_d = 1'b0;
		else if (ctrl_mode)
		begin
			// Short high kick, then the external pull-up holds the line.
			if (!prev_q)
				cnt_d = PULSE_CYC - 8'h01;
			oe_d = !prev_q || (cnt_q != 8'h00);
		end
	end

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_q  <= 8'h00;
			prev_q <= 1'b0;
			out_q  <= 1'b0;
			oe_q   <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			prev_q <= val;
			out_q  <= out_d;
			oe_q   <= oe_d;
		end
	end

	assign pin_out = out_q;
	assign pin_oe  = oe_q;

endmodule // khmf_qpin

// ==== verilog/khmf_sync.v ====
// Two flip-flop synchroniser for pin inputs.
module khmf_sync #(
	parameter W = 1
) (
	input  wire         mclk,
	input  wire         nrst,
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);

	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// The first stage feeds only the second stage, to contain metastability.
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule // khmf_sync
